// *** mode_regs_pkg.sv ***
// Purpose: Shared constants for the mode-register bank, addresses 07H to 0CH
// Assumes: 6-bit mode-register address, 8-bit operand
// Notes:   Field positions, codes and reset values used by the top module, controller model and bench
package mode_regs_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [5:0] ADDR_REVISION    = 6'h07;
  localparam logic [5:0] ADDR_CONFIG      = 6'h08;
  localparam logic [5:0] ADDR_VENDOR_TEST = 6'h09;
  localparam logic [5:0] ADDR_CAL_RESET   = 6'h0a;
  localparam logic [5:0] ADDR_TERMINATION = 6'h0b;
  localparam logic [5:0] ADDR_CMD_REF     = 6'h0c;

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int TYPE_LSB      = 0;
  localparam int DENSITY_LSB   = 2;
  localparam int WIDTH_LSB     = 6;
  localparam int CAL_RESET_BIT = 0;
  localparam int DQ_TERM_LSB   = 0;
  localparam int CA_TERM_LSB   = 4;
  localparam int TERM_W        = 3;
  localparam int LEVEL_LSB     = 0;
  localparam int LEVEL_W       = 6;
  localparam int RANGE_BIT     = 6;
  localparam int TRAIN_BIT     = 7;

  // ---------------------------------------------------------------
  // Codes
  // ---------------------------------------------------------------
  localparam logic [1:0] TYPE_S16       = 2'h0;
  localparam logic [1:0] TYPE_LOW_VDDQ  = 2'h1;
  localparam logic [3:0] DENSITY_16GB   = 4'h4;
  localparam logic [3:0] DENSITY_MAXDUAL = 4'h6;
  localparam logic [3:0] DENSITY_2GB    = 4'hc;
  localparam logic [1:0] WIDTH_X16      = 2'h0;
  localparam logic [1:0] WIDTH_X8       = 2'h1;
  localparam logic [2:0] TERM_RESERVED  = 3'h7;
  localparam logic [5:0] LEVEL_MAX      = 6'h32;
  // Arbitrary revision value, not tied to any real die
  localparam logic [7:0] REVISION_DEFAULT = 8'h5a;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] TERM_RESET  = 3'h0;
  localparam logic [5:0] LEVEL_RESET = 6'h00;
  localparam logic       RANGE_RESET = 1'b1;
  localparam logic       TRAIN_RESET = 1'b0;
  localparam logic [7:0] READ_ZERO   = 8'h00;

endpackage

// *** set_point_pair.sv ***
// Purpose: One field held as two copies, one per frequency set point
// Assumes: Write and operating selects come from logic on the same clock
// Notes:   Write view follows the write select, active view the operating one
module set_point_pair #(
  parameter int             W     = 3,
  parameter logic [W-1:0]   RESET = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // Update
  input  wire logic         wr_en,
  input  wire logic         wr_sel,
  input  wire logic [W-1:0] wr_data,
  // Views
  input  wire logic         op_sel,
  output logic      [W-1:0] wr_view,
  output logic      [W-1:0] op_view
);

  typedef struct packed {
    logic [W-1:0] copy1;
    logic [W-1:0] copy0;
  } pair_t;

  pair_t s_reg;
  pair_t s_next;

  always_comb begin
    s_next = s_reg;
    if (wr_en && wr_sel) begin
      s_next.copy1 = wr_data;
    end
    if (wr_en && !wr_sel) begin
      s_next.copy0 = wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '{copy1: RESET, copy0: RESET};
    end else begin
      s_reg <= s_next;
    end
  end

  assign wr_view = wr_sel ? s_reg.copy1 : s_reg.copy0;
  assign op_view = op_sel ? s_reg.copy1 : s_reg.copy0;

endmodule

// *** calibration_ctrl.sv ***
// Purpose: Output calibration state: default versus calibrated
// Assumes: resistor_present is already synchronised
// Notes:   Reset request wins over a calibration command in the same cycle
module calibration_ctrl (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Requests
  input  wire logic resistor_present,
  input  wire logic cal_cmd,
  input  wire logic cal_reset_req,
  // State
  output logic      default_cal,
  output logic      cal_start
);

  typedef struct packed {
    logic default_cal;
    logic cal_start;
  } cal_t;

  cal_t s_reg;
  cal_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.cal_start = resistor_present && cal_cmd && !cal_reset_req;
    if (!resistor_present || cal_reset_req) begin
      s_next.default_cal = 1'b1;
    end else if (cal_cmd) begin
      s_next.default_cal = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '{default_cal: 1'b1, cal_start: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

  assign default_cal = s_reg.default_cal;
  assign cal_start   = s_reg.cal_start;

endmodule

// *** dram_mode_regs_7_to_12.sv ***
// Purpose: Mode registers 07H to 0CH of a low-power DRAM die
// Assumes: Mode-register commands arrive decoded on the DRAM clock
// Notes:   Set-point selects come from the set_point_control register
//
// Overview of operation
// [RULE1] 07H reads fixed second revision code
// [RULE2] 08H reads type, density and width
// [RULE3] Type field: 00 prefetch, 01 low-supply
// [RULE4] Density field encodes die capacity
// [RULE5] Width field: 00 x16, 01 x8
// [RULE6] Controller writes only 00H to 09H
// [RULE7] 0AH bit0 one triggers calibration reset
// [RULE8] Grounded pin: default calibration, commands ignored
// [RULE9] 0BH low bits pick data termination
// [RULE10] 0BH bits 6:4 pick command termination
// [RULE11] Writes update only the write-selected copy
// [RULE12] 0CH read returns the write-selected copy
// [RULE13] Device runs on operating-selected copy only
// [RULE14] 0CH low six bits set reference level
// [RULE15] 0CH bit6 picks range, default one
// [RULE16] Range held until overwritten or reset
// [RULE17] 0CH read drives eight bits, rest zero
// [RULE18] 0CH bit7 picks training mode, x8 only
// [RULE19] Write select is set_point_control bit6
// [RULE20] Operating select is set_point_control bit7
// [RULE21] Writes to read-only registers are ignored
module dram_mode_regs_7_to_12 #(
  parameter logic [7:0] REVISION_ID = mode_regs_pkg::REVISION_DEFAULT,
  parameter logic [1:0] DIE_TYPE    = mode_regs_pkg::TYPE_LOW_VDDQ,
  parameter logic [3:0] DENSITY     = mode_regs_pkg::DENSITY_16GB,
  parameter logic [1:0] IO_WIDTH    = mode_regs_pkg::WIDTH_X8
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Mode-register commands
  input  wire logic       mrw_valid,
  input  wire logic       mrr_valid,
  input  wire logic [5:0] mr_addr,
  input  wire logic [7:0] mr_wdata,
  // Set-point selects
  input  wire logic       write_set_point_select,
  input  wire logic       operating_set_point_select,
  // Calibration
  input  wire logic       zq_resistor_pin,
  input  wire logic       cal_cmd,
  // Read answer
  output logic            mrr_rdata_valid,
  output logic      [7:0] mrr_rdata,
  // Active settings
  output logic      [2:0] data_bus_termination,
  output logic      [2:0] command_bus_termination,
  output logic      [5:0] command_reference_level,
  output logic            command_reference_range,
  output logic            command_training_mode,
  // Calibration and vendor-test state
  output logic            calibration_reset,
  output logic            calibration_start,
  output logic            default_calibration,
  output logic            vendor_test_engaged
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       zq_meta;
    logic       zq_sync;
    logic       train_mode;
    logic       rd_valid;
    logic [7:0] rd_data;
    logic [2:0] dq_term;
    logic [2:0] ca_term;
    logic [5:0] level;
    logic       range;
    logic       train_out;
    logic       cal_reset;
    logic       test_engaged;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic       wr_term, wr_ref;
  logic       dq_ok, ca_ok, level_ok;
  logic [2:0] dq_op_view, ca_op_view;
  logic [5:0] level_wr_view, level_op_view;
  logic       range_wr_view, range_op_view;
  logic       cal_default, cal_start;
  logic [7:0] config_word;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  assign wr_term = mrw_valid && (mr_addr == mode_regs_pkg::ADDR_TERMINATION);
  assign wr_ref  = mrw_valid && (mr_addr == mode_regs_pkg::ADDR_CMD_REF);

  // [RULE9] reserved data code refused
  assign dq_ok = mr_wdata[mode_regs_pkg::DQ_TERM_LSB +: mode_regs_pkg::TERM_W]
                 != mode_regs_pkg::TERM_RESERVED;
  // [RULE10] reserved command code refused
  assign ca_ok = mr_wdata[mode_regs_pkg::CA_TERM_LSB +: mode_regs_pkg::TERM_W]
                 != mode_regs_pkg::TERM_RESERVED;
  // [RULE14] reserved levels refused
  assign level_ok =
    mr_wdata[mode_regs_pkg::LEVEL_LSB +: mode_regs_pkg::LEVEL_W]
    <= mode_regs_pkg::LEVEL_MAX;

  // [RULE2] configuration word
  assign config_word = {IO_WIDTH, DENSITY, DIE_TYPE};

  // ---------------------------------------------------------------
  // Set-point copies
  // ---------------------------------------------------------------
  // [RULE11] [RULE19] [RULE20] two copies per field
  set_point_pair #(
    .W     (mode_regs_pkg::TERM_W),
    .RESET (mode_regs_pkg::TERM_RESET)
  ) u_dq_term (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (wr_term && dq_ok),
    .wr_sel  (write_set_point_select),
    .wr_data (mr_wdata[mode_regs_pkg::DQ_TERM_LSB +: mode_regs_pkg::TERM_W]),
    .op_sel  (operating_set_point_select),
    .wr_view (),
    .op_view (dq_op_view)
  );

  set_point_pair #(
    .W     (mode_regs_pkg::TERM_W),
    .RESET (mode_regs_pkg::TERM_RESET)
  ) u_ca_term (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (wr_term && ca_ok),
    .wr_sel  (write_set_point_select),
    .wr_data (mr_wdata[mode_regs_pkg::CA_TERM_LSB +: mode_regs_pkg::TERM_W]),
    .op_sel  (operating_set_point_select),
    .wr_view (),
    .op_view (ca_op_view)
  );

  set_point_pair #(
    .W     (mode_regs_pkg::LEVEL_W),
    .RESET (mode_regs_pkg::LEVEL_RESET)
  ) u_level (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (wr_ref && level_ok),
    .wr_sel  (write_set_point_select),
    .wr_data (mr_wdata[mode_regs_pkg::LEVEL_LSB +: mode_regs_pkg::LEVEL_W]),
    .op_sel  (operating_set_point_select),
    .wr_view (level_wr_view),
    .op_view (level_op_view)
  );

  // [RULE15] [RULE16] range default one, kept
  set_point_pair #(
    .W     (1),
    .RESET (mode_regs_pkg::RANGE_RESET)
  ) u_range (
    .clk     (clk),
    .reset   (reset),
    .wr_en   (wr_ref),
    .wr_sel  (write_set_point_select),
    .wr_data (mr_wdata[mode_regs_pkg::RANGE_BIT]),
    .op_sel  (operating_set_point_select),
    .wr_view (range_wr_view),
    .op_view (range_op_view)
  );

  // ---------------------------------------------------------------
  // Calibration
  // ---------------------------------------------------------------
  // [RULE8] pin strap decides support
  calibration_ctrl u_cal (
    .clk              (clk),
    .reset            (reset),
    .resistor_present (s_reg.zq_sync),
    .cal_cmd          (cal_cmd),
    .cal_reset_req    (s_reg.cal_reset),
    .default_cal      (cal_default),
    .cal_start        (cal_start)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.zq_meta = zq_resistor_pin;
    s_next.zq_sync = s_reg.zq_meta;

    // [RULE7] self-clearing reset trigger
    s_next.cal_reset = mrw_valid
                       && (mr_addr == mode_regs_pkg::ADDR_CAL_RESET)
                       && mr_wdata[mode_regs_pkg::CAL_RESET_BIT];

    // [RULE6] flag values other than zero
    if (mrw_valid && (mr_addr == mode_regs_pkg::ADDR_VENDOR_TEST)) begin
      s_next.test_engaged = (mr_wdata != mode_regs_pkg::READ_ZERO);
    end

    // [RULE18] single-copy training mode
    if (wr_ref) begin
      s_next.train_mode = mr_wdata[mode_regs_pkg::TRAIN_BIT];
    end

    // [RULE13] operating copy drives outputs
    s_next.dq_term   = dq_op_view;
    s_next.ca_term   = ca_op_view;
    s_next.level     = level_op_view;
    s_next.range     = range_op_view;
    s_next.train_out = s_reg.train_mode
                       && (IO_WIDTH == mode_regs_pkg::WIDTH_X8);

    // [RULE17] read answer, reserved zero
    s_next.rd_valid = mrr_valid
                      && (mr_addr >= mode_regs_pkg::ADDR_REVISION)
                      && (mr_addr <= mode_regs_pkg::ADDR_CMD_REF);
    s_next.rd_data  = mode_regs_pkg::READ_ZERO;
    if (mrr_valid) begin
      case (mr_addr)
        // [RULE1] revision code
        mode_regs_pkg::ADDR_REVISION: s_next.rd_data = REVISION_ID;
        // [RULE3] [RULE4] [RULE5] configuration fields
        mode_regs_pkg::ADDR_CONFIG: s_next.rd_data = config_word;
        // [RULE12] write-selected copy read
        mode_regs_pkg::ADDR_CMD_REF: begin
          s_next.rd_data = {s_reg.train_mode, range_wr_view, level_wr_view};
        end
        default: s_next.rd_data = mode_regs_pkg::READ_ZERO;
      endcase
    end
    // [RULE21] no path writes 07H or 08H
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '{
        zq_meta: 1'b0, zq_sync: 1'b0,
        train_mode: mode_regs_pkg::TRAIN_RESET,
        rd_valid: 1'b0, rd_data: mode_regs_pkg::READ_ZERO,
        dq_term: mode_regs_pkg::TERM_RESET, ca_term: mode_regs_pkg::TERM_RESET,
        level: mode_regs_pkg::LEVEL_RESET, range: mode_regs_pkg::RANGE_RESET,
        train_out: 1'b0, cal_reset: 1'b0, test_engaged: 1'b0
      };
    end else begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign mrr_rdata_valid         = s_reg.rd_valid;
  assign mrr_rdata               = s_reg.rd_data;
  assign data_bus_termination    = s_reg.dq_term;
  assign command_bus_termination = s_reg.ca_term;
  assign command_reference_level = s_reg.level;
  assign command_reference_range = s_reg.range;
  assign command_training_mode   = s_reg.train_out;
  assign calibration_reset       = s_reg.cal_reset;
  assign calibration_start       = cal_start;
  assign default_calibration     = cal_default;
  assign vendor_test_engaged     = s_reg.test_engaged;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_revision_read;
    mrr_valid && (mr_addr == mode_regs_pkg::ADDR_REVISION)
      |=> mrr_rdata_valid && (mrr_rdata == REVISION_ID);
  endproperty
  a_revision_read: assert property (p_revision_read) // [RULE1]
    else $error("revision read wrong");

  property p_config_read;
    mrr_valid && (mr_addr == mode_regs_pkg::ADDR_CONFIG)
      |=> (mrr_rdata[7:6] == IO_WIDTH) && (mrr_rdata[5:2] == DENSITY)
          && (mrr_rdata[1:0] == DIE_TYPE);
  endproperty
  a_config_read: assert property (p_config_read) // [RULE2]
    else $error("configuration read wrong");

  property p_cal_reset;
    mrw_valid && (mr_addr == mode_regs_pkg::ADDR_CAL_RESET) && mr_wdata[0]
      |=> calibration_reset ##1 (default_calibration && !calibration_start);
  endproperty
  a_cal_reset: assert property (p_cal_reset) // [RULE7]
    else $error("calibration reset not applied");

  property p_grounded_pin;
    !s_reg.zq_sync |=> default_calibration && !calibration_start;
  endproperty
  a_grounded_pin: assert property (p_grounded_pin) // [RULE8]
    else $error("calibration ran with grounded pin");

  property p_term_legal;
    (data_bus_termination != mode_regs_pkg::TERM_RESERVED)
      && (command_bus_termination != mode_regs_pkg::TERM_RESERVED);
  endproperty
  a_term_legal: assert property (p_term_legal) // [RULE9]
    else $error("reserved termination code active");

  property p_inactive_write;
    (wr_term && (write_set_point_select != operating_set_point_select))
      ##1 (!mrw_valid && $stable(operating_set_point_select))
      |=> $stable(data_bus_termination) && $stable(command_bus_termination);
  endproperty
  a_inactive_write: assert property (p_inactive_write) // [RULE11]
    else $error("inactive copy write disturbed operation");

  property p_read_back;
    (wr_ref && level_ok) ##1 (!mrw_valid && $stable(write_set_point_select))
      ##1 (mrr_valid && !mrw_valid && (mr_addr == mode_regs_pkg::ADDR_CMD_REF)
           && $stable(write_set_point_select))
      |=> mrr_rdata == $past(mr_wdata, 3);
  endproperty
  a_read_back: assert property (p_read_back) // [RULE12]
    else $error("reference read does not match write");

  property p_level_legal;
    command_reference_level <= mode_regs_pkg::LEVEL_MAX;
  endproperty
  a_level_legal: assert property (p_level_legal) // [RULE14]
    else $error("reserved reference level active");

  property p_range_reset;
    disable iff (1'b0) $fell(reset) |-> command_reference_range;
  endproperty
  a_range_reset: assert property (p_range_reset) // [RULE15]
    else $error("range not one after reset");

  property p_read_answer;
    mrr_valid && (mr_addr >= mode_regs_pkg::ADDR_REVISION)
      && (mr_addr <= mode_regs_pkg::ADDR_CMD_REF) |=> mrr_rdata_valid;
  endproperty
  a_read_answer: assert property (p_read_answer) // [RULE17]
    else $error("read not answered");

  property p_train_width;
    wr_ref ##1 !wr_ref |=> command_training_mode
      == ($past(mr_wdata[mode_regs_pkg::TRAIN_BIT], 2)
          && (IO_WIDTH == mode_regs_pkg::WIDTH_X8));
  endproperty
  a_train_width: assert property (p_train_width) // [RULE18]
    else $error("training mode outside x8");

  c_switch_set_point: cover property (
    wr_ref ##1 $changed(operating_set_point_select));
  c_cal_cycle: cover property (calibration_start ##[1:20] calibration_reset);
  c_ref_read: cover property (
    mrr_valid && (mr_addr == mode_regs_pkg::ADDR_CMD_REF));

endmodule

// *** cmd_ctrl.sv ***
// Purpose: Controller model issuing mode-register writes and reads
// Assumes: One-cycle strobes, answer sampled one cycle after the read
// Notes:   Idle command lines show the inverse of the last value
module cmd_ctrl (
  // Clock
  input  wire logic       clk,
  // Commands
  output logic            mrw_valid,
  output logic            mrr_valid,
  output logic      [5:0] mr_addr,
  output logic      [7:0] mr_wdata,
  // Read answer
  input  wire logic       mrr_rdata_valid,
  input  wire logic [7:0] mrr_rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // Command tasks
  // ---------------------------------------------------------------
  initial begin
    mrw_valid = 1'b0;
    mrr_valid = 1'b0;
    mr_addr   = 6'h3f;
    mr_wdata  = 8'ha5;
  end

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    mrw_valid <= 1'b1;
    mr_addr   <= a;
    mr_wdata  <= (a == mode_regs_pkg::ADDR_VENDOR_TEST) ? 8'h00 : d;
    @(posedge clk);
    mrw_valid <= 1'b0;
    mr_addr   <= ~a;
    mr_wdata  <= ~d;
  endtask

  task automatic rd(input logic [5:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk);
    mrr_valid <= 1'b1;
    mr_addr   <= a;
    @(posedge clk);
    mrr_valid <= 1'b0;
    mr_addr   <= ~a;
    #1;
    v = mrr_rdata_valid;
    d = mrr_rdata;
  endtask
endmodule

// *** dram_mode_regs_7_to_12_bench.sv ***
// Purpose: Self-checking bench for mode registers 07H to 0CH
// Assumes: x8 die, 20 MHz clock, synchronous active-high reset
// Notes:   Expected values come from the field layout and codes
module dram_mode_regs_7_to_12_bench;
  timeunit 1ns;
  timeprecision 1ns;

  // Arbitrary revision value
  localparam logic [7:0] REV = 8'h3c;
  localparam logic [7:0] CFG = {mode_regs_pkg::WIDTH_X8,
    mode_regs_pkg::DENSITY_MAXDUAL, mode_regs_pkg::TYPE_S16};

  logic       clk, reset, mrw_valid, mrr_valid, wsel, osel, pin, cal_cmd;
  logic       rv, cal_rst, cal_go, def_cal, vend, range_o, train_o;
  logic [5:0] mr_addr, level_o;
  logic [7:0] mr_wdata, rdata;
  logic [2:0] dq_t, ca_t;
  int         err_count = 0;
  int         total_checks = 0;
  int         cycles = 0;

  // ---------------------------------------------------------------
  // Design, controller model, clock
  // ---------------------------------------------------------------
  dram_mode_regs_7_to_12 #(.REVISION_ID(REV),
    .DIE_TYPE(mode_regs_pkg::TYPE_S16),
    .DENSITY(mode_regs_pkg::DENSITY_MAXDUAL),
    .IO_WIDTH(mode_regs_pkg::WIDTH_X8)) dram_mode_regs_7_to_12_i (
    .clk(clk), .reset(reset), .mrw_valid(mrw_valid),
    .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata),
    .write_set_point_select(wsel), .operating_set_point_select(osel),
    .zq_resistor_pin(pin), .cal_cmd(cal_cmd), .mrr_rdata_valid(rv),
    .mrr_rdata(rdata), .data_bus_termination(dq_t),
    .command_bus_termination(ca_t), .command_reference_level(level_o),
    .command_reference_range(range_o), .command_training_mode(train_o),
    .calibration_reset(cal_rst), .calibration_start(cal_go),
    .default_calibration(def_cal), .vendor_test_engaged(vend));

  cmd_ctrl cmd_ctrl_i (.clk(clk), .mrw_valid(mrw_valid),
    .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata),
    .mrr_rdata_valid(rv), .mrr_rdata(rdata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask

  task automatic rdc(input logic [5:0] a, input logic [7:0] e,
                     input logic ev);
    logic [7:0] d;
    logic       v;
    cmd_ctrl_i.rd(a, d, v);
    check("read valid", {7'h00, v}, {7'h00, ev});
    check("read data", d, e);
  endtask

  task automatic act(input logic [2:0] dq, ca, input logic [7:0] r);
    repeat (2) @(posedge clk);
    #1;
    check("termination", {1'b0, ca_t, 1'b0, dq_t}, {1'b0, ca, 1'b0, dq});
    check("reference", {train_o, range_o, level_o}, r);
  endtask

  task automatic cal_pulse(input logic [7:0] e);
    @(posedge clk);
    cal_cmd <= 1'b1;
    @(posedge clk);
    cal_cmd <= 1'b0;
    #1;
    check("calibration", {6'h00, cal_go, def_cal}, e);
  endtask

  task automatic do_reset;
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task results;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    wsel = 1'b0;
    osel = 1'b0;
    pin = 1'b1;
    cal_cmd = 1'b0;
    do_reset();
    check("flags", {rv, cal_rst, cal_go, def_cal, vend, 3'h0},
          8'h10);
    act(3'h0, 3'h0, 8'h40);
    rdc(mode_regs_pkg::ADDR_REVISION, REV, 1'b1);
    rdc(mode_regs_pkg::ADDR_CONFIG, CFG,
        1'b1);
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_REVISION, ~REV);
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_CONFIG, ~CFG);
    rdc(mode_regs_pkg::ADDR_REVISION, REV, 1'b1);
    rdc(mode_regs_pkg::ADDR_CONFIG, CFG, 1'b1);
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_VENDOR_TEST, 8'h00);
    rdc(mode_regs_pkg::ADDR_VENDOR_TEST, 8'h00, 1'b1);
    rdc(mode_regs_pkg::ADDR_CAL_RESET, 8'h00, 1'b1);
    rdc(mode_regs_pkg::ADDR_TERMINATION, 8'h00, 1'b1);
    rdc(6'h0d, 8'h00, 1'b0);
    check("vendor", {7'h00, vend}, 8'h00);
    // Every termination code on set point 0
    for (int c = 0; c < 7; c++) begin
      cmd_ctrl_i.wr(mode_regs_pkg::ADDR_TERMINATION,
                    {1'b0, 3'(c), 1'b0, 3'(6 - c)});
      act(3'(6 - c), 3'(c), 8'h40);
    end
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_TERMINATION, 8'h72);
    act(3'h2, 3'h6, 8'h40);
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_TERMINATION, 8'h17);
    act(3'h2, 3'h1, 8'h40);
    // Inactive copy, then switch to it
    @(posedge clk) wsel <= 1'b1;
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_TERMINATION, 8'h45);
    act(3'h2, 3'h1, 8'h40);
    @(posedge clk) osel <= 1'b1;
    act(3'h5, 3'h4, 8'h40);
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_CMD_REF, 8'hb2);
    rdc(mode_regs_pkg::ADDR_CMD_REF, 8'hb2, 1'b1);
    act(3'h5, 3'h4, 8'hb2);
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_CMD_REF, 8'h73);
    act(3'h5, 3'h4, 8'h72);
    rdc(mode_regs_pkg::ADDR_CMD_REF, 8'h72, 1'b1);
    @(posedge clk) wsel <= 1'b0;
    rdc(mode_regs_pkg::ADDR_CMD_REF, 8'h40, 1'b1);
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_CMD_REF, 8'h85);
    act(3'h5, 3'h4, 8'hf2);
    @(posedge clk) osel <= 1'b0;
    act(3'h2, 3'h1, 8'h85);
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_TERMINATION, 8'h00);
    act(3'h0, 3'h0, 8'h85);
    // Calibration with the resistor fitted, then grounded
    cal_pulse(8'h02);
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_CAL_RESET, 8'h01);
    #1;
    check("cal reset", {6'h00, cal_rst, def_cal}, 8'h02);
    @(posedge clk);
    #1;
    check("cal reset", {6'h00, cal_rst, def_cal}, 8'h01);
    @(posedge clk) pin <= 1'b0;
    repeat (3) @(posedge clk);
    cal_pulse(8'h01);
    cmd_ctrl_i.wr(mode_regs_pkg::ADDR_CAL_RESET, 8'h00);
    #1;
    check("cal reset", {6'h00, cal_rst, def_cal}, 8'h01);
    do_reset();
    act(3'h0, 3'h0, 8'h40);
    results();
  end
endmodule
